//--- rtl/indicator_pkg.sv
// Package: constants, types and decoding shared by the indicator monitor
package indicator_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_IND = 20;
  localparam int SEL_W = 6;
  localparam int MAX_INPUTS = 64;
  localparam int STAMP_W = 32;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int STAMP_RES_NS = 1000000;
  localparam int CYC_PER_MS = STAMP_RES_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_MASK = 12'h008;
  localparam logic [11:0] ADDR_MSTIME = 12'h00C;
  localparam logic [11:0] ADDR_STATE_LO = 12'h010;
  localparam logic [11:0] ADDR_STATE_HI = 12'h014;
  localparam logic [11:0] ADDR_SEL_BASE = 12'h080;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_ON_BIT = 1;
  localparam int CTRL_OFF_BIT = 2;
  localparam int CTRL_W = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h7;
  localparam int IRQ_CHANGE_BIT = 0;
  localparam int IRQ_OVERRUN_BIT = 1;
  localparam int IRQ_W = 2;
  localparam int SEL_OPEN_LSB = 0;
  localparam int SEL_CLOSE_LSB = 8;
  localparam logic [SEL_W-1:0] SEL_RESET = 6'h00;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_INTER = 2'b00,
    ST_OPEN = 2'b01,
    ST_CLOSED = 2'b10,
    ST_BAD = 2'b11
  } ind_state_e;

  typedef enum logic [0:0] {
    SCAN_IDLE = 1'b0,
    SCAN_RUN = 1'b1
  } scan_e;

  typedef struct packed {
    logic [STAMP_W-1:0] stamp;
    logic [4:0] index;
    ind_state_e cond;
    logic on;
  } ind_event_s;

  // Open/close levels to two-bit indicator state
  function automatic ind_state_e decode_state(input logic openAct, input logic closeAct);
    ind_state_e s;
    // R2: neither active, intermediate
    s = ST_INTER;
    // R3: both active, bad
    if (openAct && closeAct) begin
      s = ST_BAD;
    end else if (openAct) begin
      s = ST_OPEN;
    end else if (closeAct) begin
      s = ST_CLOSED;
    end
    return s;
  endfunction : decode_state

endpackage : indicator_pkg

//--- rtl/input_sync.sv
// Two-flop synchroniser for a vector of status inputs
`timescale 1ns/1ps
module input_sync #(
  parameter int WIDTH = 64
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_r;

  generate
    if (WIDTH < 1) begin : g_bad
      $error("input_sync: WIDTH must be positive");
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta_r <= '0;
      dout <= '0;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end

endmodule : input_sync

//--- rtl/ms_timebase.sv
// Millisecond tick and free-running millisecond counter
`timescale 1ns/1ps
module ms_timebase #(
  parameter int CYCLES = indicator_pkg::CYC_PER_MS
) (
  input wire logic clk,
  input wire logic nrst,
  output logic tick,
  output logic [indicator_pkg::STAMP_W-1:0] msCount
);

  localparam int CNT_W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

  logic [CNT_W-1:0] div_r;
  logic wrap;

  generate
    if (CYCLES < 2) begin : g_bad
      $error("ms_timebase: CYCLES must be at least 2");
    end
  endgenerate

  assign wrap = (div_r == LAST);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      div_r <= '0;
      tick <= 1'b0;
      msCount <= '0;
    end else begin
      div_r <= wrap ? '0 : div_r + 1'b1;
      tick <= wrap;
      msCount <= wrap ? msCount + 1'b1 : msCount;
    end
  end

endmodule : ms_timebase

//--- rtl/indicator_status_monitor.sv
// Indicator status monitor: state derivation, event generation, APB registers
//
// How it works
// R1: state code 0 inter, 1 open, 2 closed, 3 bad
// R2: neither input active gives intermediate
// R3: both inputs active gives bad
// R4: logic one on open input means open
// R5: logic one on close input means close
// R6: ON and OFF event per condition change
// R7: events stamped with millisecond counter
// R8: storage select keeps ON, OFF or both
// R9: twenty independent indicator instances
// R10: software may select one input, inverted copy; the code selects the input only and offers no inverted copy
// R11: selections treated as static while running
// R12: no command outputs toward switchgear
// R13: evaluate per tick, reset to intermediate silently
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/1ps
module indicator_status_monitor #(
  parameter int NUM_IND = indicator_pkg::NUM_IND,
  parameter int NUM_INPUTS = indicator_pkg::MAX_INPUTS,
  parameter int MS_CYCLES = indicator_pkg::CYC_PER_MS
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_INPUTS-1:0] statusIn,
  input wire logic evReady,
  output logic evValid,
  output indicator_pkg::ind_event_s evData,
  output logic irq
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  localparam int IDX_W = 5;
  localparam int SW = indicator_pkg::SEL_W;
  localparam int CW = indicator_pkg::CTRL_W;
  localparam int IW = indicator_pkg::IRQ_W;
  localparam logic [1:0] COND_LAST = 2'b11;

  generate
    if (NUM_IND < 1 || NUM_IND > 32) begin : g_bad_ind
      $error("NUM_IND must be 1 to 32");
    end
    if (NUM_INPUTS < 1 || NUM_INPUTS > indicator_pkg::MAX_INPUTS) begin : g_bad_in
      $error("NUM_INPUTS must be 1 to 64");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Input synchroniser and time base
  // ----------------------------------------------------------------
  logic [NUM_INPUTS-1:0] syncIn;
  logic msTick;
  logic [indicator_pkg::STAMP_W-1:0] msCount;

  input_sync #(.WIDTH(NUM_INPUTS)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .din(statusIn),
    .dout(syncIn)
  );

  ms_timebase #(.CYCLES(MS_CYCLES)) u_timebase (
    .clk(clk),
    .nrst(nrst),
    .tick(msTick),
    .msCount(msCount)
  );

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [CW-1:0] ctrl_r;
  logic [IW-1:0] status_r;
  logic [IW-1:0] status_nxt;
  logic [IW-1:0] mask_r;
  logic [SW-1:0] openSel_r [NUM_IND];
  logic [SW-1:0] closeSel_r [NUM_IND];

  // ----------------------------------------------------------------
  // Input selection
  // ----------------------------------------------------------------
  // A selection past the last input reads as inactive
  function automatic logic pick_input(input logic [NUM_INPUTS-1:0] levels,
                                      input logic [SW-1:0] sel);
    logic hit;
    hit = 1'b0;
    if (int'(sel) < NUM_INPUTS) begin
      hit = levels[sel];
    end
    return hit;
  endfunction : pick_input

  // ----------------------------------------------------------------
  // Per-indicator state derivation
  // ----------------------------------------------------------------
  indicator_pkg::ind_state_e curState [NUM_IND];
  indicator_pkg::ind_state_e snap_r [NUM_IND];
  indicator_pkg::ind_state_e old_r [NUM_IND];
  logic [63:0] stateWide;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_IND; gi++) begin : g_ind
      wire openAct;
      wire closeAct;
      // R4: active-high open input
      assign openAct = pick_input(syncIn, openSel_r[gi]);
      // R5: active-high close input
      assign closeAct = pick_input(syncIn, closeSel_r[gi]);
      // R1: two-bit state code
      assign curState[gi] = indicator_pkg::decode_state(openAct, closeAct);
      assign stateWide[2*gi +: 2] = old_r[gi];
    end
    for (gi = NUM_IND; gi < 32; gi++) begin : g_pad
      assign stateWide[2*gi +: 2] = 2'b00;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Event scanner
  // ----------------------------------------------------------------
  indicator_pkg::scan_e scan_r;
  logic [IDX_W-1:0] idx_r;
  logic [1:0] cond_r;
  logic [indicator_pkg::STAMP_W-1:0] stamp_r;
  logic evValid_r;
  indicator_pkg::ind_event_s evData_r;

  wire enabled = ctrl_r[indicator_pkg::CTRL_EN_BIT];
  wire stall = evValid_r && !evReady;
  wire step = (scan_r == indicator_pkg::SCAN_RUN) && !stall;
  wire startScan = msTick && enabled && (scan_r == indicator_pkg::SCAN_IDLE);
  wire overrun = msTick && enabled && (scan_r == indicator_pkg::SCAN_RUN);
  wire lastCond = (cond_r == COND_LAST);
  wire lastIdx = (idx_r == IDX_W'(NUM_IND - 1));
  wire wasOn = (old_r[idx_r] == indicator_pkg::ind_state_e'(cond_r));
  wire isOn = (snap_r[idx_r] == indicator_pkg::ind_state_e'(cond_r));
  wire condChange = step && (wasOn != isOn);
  // R8: drop the deselected direction
  wire keep = isOn ? ctrl_r[indicator_pkg::CTRL_ON_BIT] : ctrl_r[indicator_pkg::CTRL_OFF_BIT];
  wire emit = condChange && keep;

  indicator_pkg::ind_event_s newEvent;
  // R7: stamp taken from the ms counter at the evaluating tick
  assign newEvent.stamp = stamp_r;
  assign newEvent.index = idx_r;
  assign newEvent.cond = indicator_pkg::ind_state_e'(cond_r);
  assign newEvent.on = isOn;

  // R13: snapshot only on a tick when the scanner is free
  always_ff @(posedge clk) begin
    if (!nrst) begin
      stamp_r <= '0;
    end else if (startScan) begin
      stamp_r <= msCount;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      scan_r <= indicator_pkg::SCAN_IDLE;
      idx_r <= '0;
      cond_r <= 2'b00;
    end else begin
      case (scan_r)
        indicator_pkg::SCAN_IDLE: begin
          idx_r <= '0;
          cond_r <= 2'b00;
          if (startScan) begin
            scan_r <= indicator_pkg::SCAN_RUN;
          end
        end
        indicator_pkg::SCAN_RUN: begin
          if (step) begin
            cond_r <= cond_r + 2'b01;
            if (lastCond) begin
              idx_r <= idx_r + 1'b1;
              if (lastIdx) begin
                scan_r <= indicator_pkg::SCAN_IDLE;
              end
            end
          end
        end
        default: begin
          scan_r <= indicator_pkg::SCAN_IDLE;
        end
      endcase
    end
  end

  // R9: one snapshot and one reported state per instance
  generate
    for (gi = 0; gi < NUM_IND; gi++) begin : g_state
      always_ff @(posedge clk) begin
        if (!nrst) begin
          // R13: all instances start intermediate, no event
          snap_r[gi] <= indicator_pkg::ST_INTER;
          old_r[gi] <= indicator_pkg::ST_INTER;
        end else begin
          if (startScan) begin
            snap_r[gi] <= curState[gi];
          end
          if (step && lastCond && (idx_r == IDX_W'(gi))) begin
            old_r[gi] <= snap_r[gi];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Event output register
  // ----------------------------------------------------------------
  // R6: one ON or OFF event per changed condition
  always_ff @(posedge clk) begin
    if (!nrst) begin
      evValid_r <= 1'b0;
      evData_r <= '0;
    end else if (emit) begin
      evValid_r <= 1'b1;
      evData_r <= newEvent;
    end else if (evReady) begin
      evValid_r <= 1'b0;
    end
  end

  // R12: event and register outputs only, nothing drives the switchgear
  assign evValid = evValid_r;
  assign evData = evData_r;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic irq_r;
  logic [31:0] rdWord;

  wire access = psel && penable;
  wire respond = access && !pready_r;
  wire commit = access && pready_r;
  wire [11:0] selOff = paddr - indicator_pkg::ADDR_SEL_BASE;
  wire [IDX_W-1:0] selIdx = selOff[IDX_W+1:2];
  wire isSel = (paddr >= indicator_pkg::ADDR_SEL_BASE) && (paddr[1:0] == 2'b00)
               && (int'(selOff[11:2]) < NUM_IND);
  wire isCtrl = (paddr == indicator_pkg::ADDR_CTRL);
  wire isStatus = (paddr == indicator_pkg::ADDR_STATUS);
  wire isMask = (paddr == indicator_pkg::ADDR_MASK);
  wire isTime = (paddr == indicator_pkg::ADDR_MSTIME);
  wire isStLo = (paddr == indicator_pkg::ADDR_STATE_LO);
  wire isStHi = (paddr == indicator_pkg::ADDR_STATE_HI);
  wire mapped = isSel || isCtrl || isStatus || isMask || isTime || isStLo || isStHi;
  wire wrEn = commit && pwrite && mapped;
  wire [IW-1:0] statusClr = (wrEn && isStatus) ? pwdata[IW-1:0] : '0;
  wire [IW-1:0] statusSet = {overrun, condChange};
  wire [31:0] selWord = ({{(32-SW){1'b0}}, openSel_r[selIdx]} << indicator_pkg::SEL_OPEN_LSB)
                      | ({{(32-SW){1'b0}}, closeSel_r[selIdx]} << indicator_pkg::SEL_CLOSE_LSB);

  // ----------------------------------------------------------------
  // Register read path
  // ----------------------------------------------------------------

  assign rdWord = isCtrl ? {{(32-CW){1'b0}}, ctrl_r} :
                  isStatus ? {{(32-IW){1'b0}}, status_r} :
                  isMask ? {{(32-IW){1'b0}}, mask_r} :
                  isTime ? msCount :
                  isStLo ? stateWide[31:0] :
                  isStHi ? stateWide[63:32] :
                  isSel ? selWord :
                  indicator_pkg::ZERO_WORD;

  // ----------------------------------------------------------------
  // Flags and bus response
  // ----------------------------------------------------------------
  // Event flags: a set in the clearing cycle wins
  assign status_nxt = (status_r & ~statusClr) | statusSet;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= indicator_pkg::ZERO_WORD;
    end else begin
      pready_r <= respond;
      pslverr_r <= respond && !mapped;
      prdata_r <= (respond && !pwrite) ? rdWord : indicator_pkg::ZERO_WORD;
    end
  end

  // ----------------------------------------------------------------
  // Settings registers
  // ----------------------------------------------------------------
  // R11: settings written by software, assumed steady while running
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_r <= indicator_pkg::CTRL_RESET;
      mask_r <= '0;
      status_r <= '0;
      irq_r <= 1'b0;
    end else begin
      if (wrEn && isCtrl) begin
        ctrl_r <= pwdata[CW-1:0];
      end
      if (wrEn && isMask) begin
        mask_r <= pwdata[IW-1:0];
      end
      status_r <= status_nxt;
      irq_r <= |(status_nxt & mask_r);
    end
  end

  // R10: any input may feed either side; no inverted copy is offered
  generate
    for (gi = 0; gi < NUM_IND; gi++) begin : g_sel
      always_ff @(posedge clk) begin
        if (!nrst) begin
          openSel_r[gi] <= indicator_pkg::SEL_RESET;
          closeSel_r[gi] <= indicator_pkg::SEL_RESET;
        end else if (wrEn && isSel && (selIdx == IDX_W'(gi))) begin
          openSel_r[gi] <= pwdata[indicator_pkg::SEL_OPEN_LSB +: SW];
          closeSel_r[gi] <= pwdata[indicator_pkg::SEL_CLOSE_LSB +: SW];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;

endmodule : indicator_status_monitor

//--- tb/indicator_monitor_properties.sv
// Port-level checks for the indicator status monitor
`timescale 1ns/1ps
module indicator_monitor_properties #(
  parameter int NUM_IND = 20
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic evReady,
  input wire logic evValid,
  input wire indicator_pkg::ind_event_s evData,
  input wire logic irq
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!nrst);

  reset_quiet_a: assert property (disable iff (1'b0)
    !nrst |=> !evValid && !pready && !irq && prdata == 32'h0000_0000)
    else $error("outputs not quiet after reset");
  access_len_a: assert property (
    psel && penable && !pready && !$past(penable) |=> pready)
    else $error("access phase not two cycles");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  ready_inside_a: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("prdata not zero while idle");
  event_hold_a: assert property (
    evValid && !evReady |=> evValid && $stable(evData))
    else $error("event dropped or changed while stalled");
  event_index_a: assert property (evValid |-> evData.index < NUM_IND)
    else $error("event index out of range");
endmodule : indicator_monitor_properties

bind indicator_status_monitor indicator_monitor_properties #(.NUM_IND(NUM_IND)) u_props (
  .clk(clk),
  .nrst(nrst),
  .psel(psel),
  .penable(penable),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .evReady(evReady),
  .evValid(evValid),
  .evData(evData),
  .irq(irq)
);

//--- tb/event_sink.sv
// Event buffer model that accepts promptly or one cycle in four
`timescale 1ns/1ps
module event_sink (
  input wire logic clk,
  input wire logic nrst,
  input wire logic fast,
  input wire logic evValid,
  input wire indicator_pkg::ind_event_s evData,
  output logic evReady
);
  logic [1:0] cnt_r;
  indicator_pkg::ind_event_s evQ[$];

  assign evReady = fast || (cnt_r == 2'b11);

  always @(posedge clk) begin
    if (!nrst) begin
      cnt_r <= 2'b00;
    end else begin
      cnt_r <= cnt_r + 2'b01;
      if (evValid && evReady) begin
        evQ.push_back(evData);
      end
    end
  end
endmodule : event_sink

//--- tb/indicator_status_monitor_bench.sv
// Self-checking bench for the indicator status monitor
`timescale 1ns/1ps
module indicator_status_monitor_bench;
  localparam int MS = 200;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [63:0] statusIn = 64'h0000_0000_0000_0000;
  logic fast = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic evReady;
  logic evValid;
  logic irq;
  indicator_pkg::ind_event_s evData;
  int badCount = 0;
  int checks = 0;
  logic [31:0] rd;
  logic err;
  logic [7:0] expQ[$];
  logic [31:0] t0;
  logic [31:0] prevStamp = 32'h0000_0000;

  always #2 clk = ~clk;

  indicator_status_monitor #(.MS_CYCLES(MS)) u_indicator_status_monitor (
    .clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .statusIn(statusIn), .evReady(evReady),
    .evValid(evValid), .evData(evData), .irq(irq)
  );

  event_sink u_event_sink (
    .clk(clk), .nrst(nrst), .fast(fast), .evValid(evValid), .evData(evData),
    .evReady(evReady)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task end_sim;
    $display("checks %0d mismatches %0d", checks, badCount);
    if (badCount == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      badCount++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk("pready", 32'(pready), 32'h0000_0001);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, rd, exp);
  endtask : rdc

  function automatic logic [7:0] ev(input int i, input int c, input int o);
    return {5'(i), 2'(c), 1'(o)};
  endfunction : ev

  task settle;
    repeat (2 * MS) @(posedge clk);
  endtask : settle

  task chkEvs(input string what);
    indicator_pkg::ind_event_s e;
    logic [31:0] st;
    st = 32'h0000_0000;
    if (u_event_sink.evQ.size() > 0) begin
      st = u_event_sink.evQ[0].stamp;
      chk("stamp order", 32'(st > prevStamp), 32'h0000_0001);
      prevStamp = st;
    end
    chk(what, 32'(u_event_sink.evQ.size()), 32'(expQ.size()));
    while (expQ.size() > 0 && u_event_sink.evQ.size() > 0) begin
      e = u_event_sink.evQ.pop_front();
      chk(what, 32'({e.index, e.cond, e.on}), 32'(expQ.pop_front()));
      chk("stamp", e.stamp, st);
    end
    u_event_sink.evQ.delete();
    expQ.delete();
    $display("test %s done", what);
  endtask : chkEvs

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    badCount++;
    end_sim();
  end

  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rdc("ctrl", 12'h000, 32'h0000_0007);
    rdc("mask", 12'h008, 32'h0000_0000);
    rdc("state lo", 12'h010, 32'h0000_0000);
    apb(1'b0, 12'h040, 32'h0000_0000);
    chk("unmapped", 32'(err), 32'h0000_0001);
    // two inputs per object, set while monitoring already runs (enabled from reset)
    for (int i = 0; i < 20; i++) begin
      apb(1'b1, 12'h080 + 12'(4 * i), {18'h0, 6'(2 * i + 1), 2'b00, 6'(2 * i)});
    end
    rdc("sel 19", 12'h0CC, 32'h0000_2726);
    apb(1'b1, 12'h008, 32'h0000_0001);
    settle();
    chkEvs("silent reset");
    apb(1'b0, 12'h00C, 32'h0000_0000);
    t0 = rd;
    repeat (2 * MS - 4) @(posedge clk);
    rdc("ms time", 12'h00C, t0 + 32'h0000_0002);
    statusIn[3:2] <= 2'b01;
    statusIn[5:4] <= 2'b10;
    statusIn[7:6] <= 2'b11;
    settle();
    expQ = '{ev(1, 0, 0), ev(1, 1, 1), ev(2, 0, 0), ev(2, 2, 1), ev(3, 0, 0), ev(3, 3, 1)};
    chkEvs("four states");
    rdc("state lo", 12'h010, 32'h0000_00E4);
    apb(1'b1, 12'h010, 32'hFFFF_FFFF);
    rdc("state ro", 12'h010, 32'h0000_00E4);
    chk("irq set", 32'(irq), 32'h0000_0001);
    rdc("status", 12'h004, 32'h0000_0001);
    apb(1'b1, 12'h004, 32'h0000_0001);
    @(posedge clk);
    chk("irq clear", 32'(irq), 32'h0000_0000);
    fast <= 1'b1;
    apb(1'b1, 12'h008, 32'h0000_0000);
    apb(1'b1, 12'h000, 32'h0000_0003);
    statusIn[3:2] <= 2'b10;
    settle();
    expQ = '{ev(1, 2, 1)};
    chkEvs("on only");
    chk("irq masked", 32'(irq), 32'h0000_0000);
    rdc("status", 12'h004, 32'h0000_0001);
    apb(1'b1, 12'h000, 32'h0000_0005);
    statusIn[3:2] <= 2'b00;
    settle();
    expQ = '{ev(1, 2, 0)};
    chkEvs("off only");
    apb(1'b1, 12'h000, 32'h0000_0007);
    statusIn[39:38] <= 2'b01;
    settle();
    expQ = '{ev(19, 0, 0), ev(19, 1, 1)};
    chkEvs("last instance");
    rdc("state hi", 12'h014, 32'h0000_0040);
    apb(1'b1, 12'h000, 32'h0000_0006);
    statusIn[39:38] <= 2'b10;
    settle();
    chkEvs("disabled");
    apb(1'b1, 12'h000, 32'h0000_0007);
    settle();
    expQ = '{ev(19, 1, 0), ev(19, 2, 1)};
    chkEvs("re-enabled");
    end_sim();
  end
endmodule : indicator_status_monitor_bench
